// ### pkg/ipa_pkg.sv
/*
  Shared constants and types of the interrupt priority arbiter:
  channel count and daisy-chain positions, register offsets, field
  positions, reset values and sequencer enumerations.
  Assumes one clock domain and an 8-bit register port.
*/
package ipa_pkg;
  localparam int NCH = 24;
  localparam int CH_W = 5;
  localparam int PRIO_W = 3;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 4;
  localparam int PC_W = 16;

  // daisy-chain positions, index 0 is highest
  localparam logic [CH_W-1:0] CH_MUX_FIRST = 5'h00;
  localparam logic [CH_W-1:0] CH_MUX_LAST = 5'h07;
  localparam logic [CH_W-1:0] CH_MFT0 = 5'h08;
  localparam logic [CH_W-1:0] CH_CAN_FIRST = 5'h09;
  localparam logic [CH_W-1:0] CH_CAN_LAST = 5'h10;
  localparam logic [CH_W-1:0] CH_ASYNC_SERIAL = 5'h11;
  localparam logic [CH_W-1:0] CH_PROTO_DECODER = 5'h12;
  localparam logic [CH_W-1:0] CH_I2C0 = 5'h13;
  localparam logic [CH_W-1:0] CH_I2C1 = 5'h14;
  localparam logic [CH_W-1:0] CH_ADC = 5'h15;
  localparam logic [CH_W-1:0] CH_MFT1 = 5'h16;
  localparam logic [CH_W-1:0] CH_MULTIPROTO_SERIAL = 5'h17;

  // register offsets
  localparam logic [ADDR_W-1:0] REG_CENTRAL_INTERRUPT_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_NESTED_PRIORITY_STACK = 4'h1;
  localparam logic [ADDR_W-1:0] REG_CODE_SEGMENT = 4'h2;
  localparam logic [ADDR_W-1:0] REG_INTERRUPT_SEGMENT = 4'h3;
  localparam logic [ADDR_W-1:0] REG_CONFIG = 4'h4;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h5;
  localparam logic [ADDR_W-1:0] REG_LAST_CHANNEL = 4'h6;

  // field positions
  localparam int CENTRAL_INTERRUPT_CTRL_CPL_LSB = 0;
  localparam int CENTRAL_INTERRUPT_CTRL_IEN_BIT = 4;
  localparam int CENTRAL_INTERRUPT_CTRL_IAM_BIT = 5;
  localparam int CFG_SEG_SAVE_BIT = 0;
  localparam int CFG_TL_MASKABLE_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_TL_ACTIVE_BIT = 1;
  localparam int STAT_USE_ISR_BIT = 2;

  // reset level, top-level priority and vector, vector address step
  localparam logic [PRIO_W-1:0] CPL_RESET = 3'h7;
  localparam logic [PRIO_W-1:0] PRIO_TOP = 3'h0;
  localparam logic [DATA_W-1:0] TL_VECTOR = 8'h04;
  localparam logic [DATA_W-1:0] VEC_STEP = 8'h01;

  typedef enum logic [3:0] {
    SQ_IDLE, SQ_EPCH, SQ_ECSR, SQ_EFLG, SQ_EVHI, SQ_EVLO, SQ_EWAIT, SQ_EEND,
    SQ_RCSR, SQ_RPCH, SQ_RPCL, SQ_RWAIT, SQ_REND
  } ipa_seq_t;

  typedef enum logic [2:0] {
    TG_NONE, TG_FLG, TG_CSR, TG_PCH, TG_PCL, TG_VHI, TG_VLO
  } ipa_tag_t;
endpackage

// ### rtl/ipa_arbiter.sv
/*
  Combinational priority arbiter: picks the eligible request with the
  lowest priority value, ties broken by daisy-chain position.
  Assumes requests come from logic on the same clock.
*/
module ipa_arbiter (
  input wire logic [ipa_pkg::NCH-1:0] irq_req,
  input wire logic [ipa_pkg::NCH*ipa_pkg::PRIO_W-1:0] irq_prio,
  input wire logic [ipa_pkg::PRIO_W-1:0] current_priority_level,
  input wire logic global_interrupt_enable,
  output logic win_valid,
  output logic [ipa_pkg::CH_W-1:0] win_idx,
  output logic [ipa_pkg::PRIO_W-1:0] win_prio
);
  import ipa_pkg::*;

  logic [NCH-1:0] eligible;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_elig
      // strictly above current level, none while disabled
      assign eligible[g] = irq_req[g] && global_interrupt_enable && (irq_prio[g*PRIO_W +: PRIO_W] < current_priority_level);
    end
  endgenerate

  // scan from chain end so the earlier position wins a tie
  always_comb begin
    win_valid = 1'b0;
    win_idx = '0;
    win_prio = CPL_RESET;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (eligible[i] && (!win_valid || irq_prio[i*PRIO_W +: PRIO_W] <= win_prio)) begin
        win_valid = 1'b1;
        win_idx = CH_W'(i);
        win_prio = irq_prio[i*PRIO_W +: PRIO_W];
      end
    end
  end
endmodule

// ### rtl/ipa_prio_stack.sv
/*
  Nested priority stack: one bit per level, set on entry, lowest set
  bit restored and cleared on return. Software may overwrite it.
  Assumes push, pop and write never coincide.
*/
module ipa_prio_stack (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic wr_en,
  input wire logic [ipa_pkg::DATA_W-1:0] wr_data,
  input wire logic push,
  input wire logic [ipa_pkg::PRIO_W-1:0] push_level,
  input wire logic pop,
  output logic [ipa_pkg::DATA_W-1:0] stack,
  output logic [ipa_pkg::PRIO_W-1:0] top_level,
  output logic top_valid,
  output logic rest_nonzero
);
  import ipa_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0] bits;
  } ipa_stk_t;

  ipa_stk_t s;
  ipa_stk_t next_s;
  logic [DATA_W-1:0] low_mask;

  // lowest set bit is the restored level
  always_comb begin
    top_level = CPL_RESET;
    for (int i = DATA_W - 1; i >= 0; i--) begin
      if (s.bits[i]) begin
        top_level = PRIO_W'(i);
      end
    end
    top_valid = |s.bits;
    low_mask = s.bits & (s.bits - DATA_W'(1));
    rest_nonzero = |low_mask;
    stack = s.bits;
  end

  always_comb begin
    next_s = s;
    if (wr_en) begin
      next_s.bits = wr_data;
    end
    if (pop && top_valid) begin
      next_s.bits[top_level] = 1'b0;
    end
    if (push) begin
      next_s.bits[push_level] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule

// ### rtl/ipa_core.sv
/*
  Interrupt priority arbiter and sequencer: arbitration at each
  instruction boundary, entry sequence (disable, pushes, vector fetch,
  segment switch), return sequence and nested priority stack.
  Assumes the core stalls while core_busy is high, pulses instr_end,
  ei_instr and iret_instr only when not busy, and that stack and
  vector reads return data one cycle after the strobe.
*/
// Local design decisions: the address map and the plain strobed port.
// Behaviour
// - same-level simultaneous requests go to the highest daisy-chain position.
// - chain: mux A0..D1, timer0, CAN E0..H1, serial, decoder, I2C, ADC, timer1, MPS.
// - current priority level is a 3-bit field, software read/write anytime.
// - mode bit clear (reset) selects concurrent, set selects nested.
// - concurrent: arbitrate each instruction, acknowledge leaves current level unchanged.
// - entry: clear enable, push PC low, high, segment if saved, flags; load vector.
// - entry: segment loaded from interrupt segment, or interrupt segment used until return.
// - return pops flags, segment if saved, PC high, PC low, then sets enable.
// - return without segment save goes back to code segment unless still nested in nested mode.
// - requests pending while disabled stay pending until enable instruction.
// - concurrent: granted level not kept; any winner taken once enabled.
// - nested entry saves current level as a set bit in the stack register.
// - nested entry then loads current level with the granted request priority.
// - nested return restores interrupted level from the stack register.
// - levels 0 highest to 7 lowest; acknowledge only at a value strictly below current.
// - current level resets to 7, so level 7 requests never win.
// - top-level request overrides all, its routine is never interrupted.
// - nested: a routine is never interrupted by its own level, eight levels deep.
module ipa_core (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [ipa_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ipa_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [ipa_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [ipa_pkg::NCH-1:0] irq_req,
  input wire logic [ipa_pkg::NCH*ipa_pkg::PRIO_W-1:0] irq_prio,
  input wire logic [ipa_pkg::NCH*ipa_pkg::DATA_W-1:0] irq_vector,
  input wire logic tl_req,
  input wire logic instr_end,
  input wire logic ei_instr,
  input wire logic iret_instr,
  input wire logic [ipa_pkg::PC_W-1:0] pc_in,
  input wire logic [ipa_pkg::DATA_W-1:0] flags_in,
  input wire logic [ipa_pkg::DATA_W-1:0] stk_rdata,
  input wire logic [ipa_pkg::DATA_W-1:0] vec_rdata,
  output logic core_busy,
  output logic irq_ack,
  output logic [ipa_pkg::CH_W-1:0] ack_channel,
  output logic tl_ack,
  output logic stk_push,
  output logic stk_pop,
  output logic [ipa_pkg::DATA_W-1:0] stk_wdata,
  output logic vec_rd,
  output logic [ipa_pkg::DATA_W-1:0] vec_addr,
  output logic pc_load,
  output logic [ipa_pkg::PC_W-1:0] pc_value,
  output logic flags_load,
  output logic [ipa_pkg::DATA_W-1:0] flags_value,
  output logic [ipa_pkg::DATA_W-1:0] code_seg,
  output logic [ipa_pkg::DATA_W-1:0] int_seg
);
  import ipa_pkg::*;

  typedef struct packed {
    ipa_seq_t seq;
    ipa_tag_t rd_tag;
    ipa_tag_t data_tag;
    logic [PRIO_W-1:0] current_priority_level;
    logic global_interrupt_enable;
    logic arbitration_mode_select;
    logic seg_save;
    logic tl_maskable;
    logic use_isr;
    logic tl_active;
    logic busy;
    logic [DATA_W-1:0] code_segment_reg;
    logic [DATA_W-1:0] interrupt_segment_reg;
    logic [DATA_W-1:0] vec;
    logic [DATA_W-1:0] flags;
    logic [PC_W-1:0] pc;
    logic [CH_W-1:0] chan;
    logic iack;
    logic tlack;
    logic push;
    logic pop;
    logic [DATA_W-1:0] wdata;
    logic vrd;
    logic [DATA_W-1:0] vaddr;
    logic pcld;
    logic flld;
    logic [DATA_W-1:0] seg_out;
    logic [DATA_W-1:0] rdata;
  } ipa_state_t;

  ipa_state_t s;
  ipa_state_t next_s;

  logic win_valid;
  logic [CH_W-1:0] win_idx;
  logic [PRIO_W-1:0] win_prio;
  logic nest_wr;
  logic nest_push;
  logic nest_pop;
  logic [DATA_W-1:0] nest_bits;
  logic [PRIO_W-1:0] nest_top;
  logic nest_top_valid;
  logic nest_rest;
  logic take_tl;
  logic take_ch;

  ipa_arbiter u_arb (
    .irq_req(irq_req),
    .irq_prio(irq_prio),
    .current_priority_level(s.current_priority_level),
    .global_interrupt_enable(s.global_interrupt_enable),
    .win_valid(win_valid),
    .win_idx(win_idx),
    .win_prio(win_prio)
  );

  ipa_prio_stack u_stack (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .wr_en(nest_wr),
    .wr_data(reg_wdata),
    .push(nest_push),
    .push_level(s.current_priority_level),
    .pop(nest_pop),
    .stack(nest_bits),
    .top_level(nest_top),
    .top_valid(nest_top_valid),
    .rest_nonzero(nest_rest)
  );

  // top level overrides, and nothing interrupts its routine
  assign take_tl = instr_end && tl_req && !s.tl_active && (s.global_interrupt_enable || !s.tl_maskable);
  assign take_ch = instr_end && win_valid && !s.tl_active;
  assign nest_wr = reg_wr && (reg_addr == REG_NESTED_PRIORITY_STACK);

  always_comb begin
    next_s = s;
    nest_push = 1'b0;
    nest_pop = 1'b0;
    next_s.iack = 1'b0;
    next_s.tlack = 1'b0;
    next_s.push = 1'b0;
    next_s.pop = 1'b0;
    next_s.vrd = 1'b0;
    next_s.pcld = 1'b0;
    next_s.flld = 1'b0;
    next_s.rd_tag = TG_NONE;
    next_s.data_tag = s.rd_tag;
    next_s.rdata = '0;

    // read data arrives one cycle after the visible strobe
    case (s.data_tag)
      TG_FLG: next_s.flags = stk_rdata;
      TG_CSR: next_s.code_segment_reg = stk_rdata;
      TG_PCH: next_s.pc[PC_W-1:DATA_W] = stk_rdata;
      TG_PCL: next_s.pc[DATA_W-1:0] = stk_rdata;
      TG_VHI: next_s.pc[PC_W-1:DATA_W] = vec_rdata;
      TG_VLO: next_s.pc[DATA_W-1:0] = vec_rdata;
      default: ;
    endcase

    // register port reads
    if (reg_rd) begin
      case (reg_addr)
        REG_CENTRAL_INTERRUPT_CTRL: begin
          next_s.rdata[CENTRAL_INTERRUPT_CTRL_CPL_LSB +: PRIO_W] = s.current_priority_level;
          next_s.rdata[CENTRAL_INTERRUPT_CTRL_IEN_BIT] = s.global_interrupt_enable;
          next_s.rdata[CENTRAL_INTERRUPT_CTRL_IAM_BIT] = s.arbitration_mode_select;
        end
        REG_NESTED_PRIORITY_STACK: next_s.rdata = nest_bits;
        REG_CODE_SEGMENT: next_s.rdata = s.code_segment_reg;
        REG_INTERRUPT_SEGMENT: next_s.rdata = s.interrupt_segment_reg;
        REG_CONFIG: begin
          next_s.rdata[CFG_SEG_SAVE_BIT] = s.seg_save;
          next_s.rdata[CFG_TL_MASKABLE_BIT] = s.tl_maskable;
        end
        REG_STATUS: begin
          next_s.rdata[STAT_BUSY_BIT] = s.busy;
          next_s.rdata[STAT_TL_ACTIVE_BIT] = s.tl_active;
          next_s.rdata[STAT_USE_ISR_BIT] = s.use_isr;
        end
        REG_LAST_CHANNEL: next_s.rdata[CH_W-1:0] = s.chan;
        default: next_s.rdata = '0;
      endcase
    end

    // register port writes, hardware updates below take precedence
    if (reg_wr) begin
      case (reg_addr)
        REG_CENTRAL_INTERRUPT_CTRL: begin
          next_s.current_priority_level = reg_wdata[CENTRAL_INTERRUPT_CTRL_CPL_LSB +: PRIO_W];
          next_s.global_interrupt_enable = reg_wdata[CENTRAL_INTERRUPT_CTRL_IEN_BIT];
          next_s.arbitration_mode_select = reg_wdata[CENTRAL_INTERRUPT_CTRL_IAM_BIT];
        end
        REG_CODE_SEGMENT: next_s.code_segment_reg = reg_wdata;
        REG_INTERRUPT_SEGMENT: next_s.interrupt_segment_reg = reg_wdata;
        REG_CONFIG: begin
          next_s.seg_save = reg_wdata[CFG_SEG_SAVE_BIT];
          next_s.tl_maskable = reg_wdata[CFG_TL_MASKABLE_BIT];
        end
        default: ;
      endcase
    end

    case (s.seq)
      SQ_IDLE: begin
        if (iret_instr) begin
          // return: flags first
          next_s.busy = 1'b1;
          next_s.pop = 1'b1;
          next_s.rd_tag = TG_FLG;
          next_s.seq = s.seg_save ? SQ_RCSR : SQ_RPCH;
        end else if (take_tl || take_ch) begin
          // acknowledge: disable first
          next_s.global_interrupt_enable = 1'b0;
          next_s.busy = 1'b1;
          if (take_tl) begin
            next_s.tl_active = 1'b1;
            next_s.tlack = 1'b1;
            next_s.vec = TL_VECTOR;
          end else begin
            next_s.iack = 1'b1;
            next_s.chan = win_idx;
            next_s.vec = irq_vector[win_idx*DATA_W +: DATA_W];
          end
          if (s.arbitration_mode_select) begin
            nest_push = 1'b1;
            next_s.current_priority_level = take_tl ? PRIO_TOP : win_prio;
          end
          // concurrent mode keeps the current level
          next_s.push = 1'b1;
          next_s.wdata = pc_in[DATA_W-1:0];
          next_s.pc = pc_in;
          next_s.flags = flags_in;
          next_s.seq = SQ_EPCH;
        end else if (ei_instr) begin
          next_s.global_interrupt_enable = 1'b1;
        end
      end
      SQ_EPCH: begin
        next_s.push = 1'b1;
        next_s.wdata = s.pc[PC_W-1:DATA_W];
        next_s.seq = s.seg_save ? SQ_ECSR : SQ_EFLG;
      end
      SQ_ECSR: begin
        next_s.push = 1'b1;
        next_s.wdata = s.code_segment_reg;
        next_s.seq = SQ_EFLG;
      end
      SQ_EFLG: begin
        next_s.push = 1'b1;
        next_s.wdata = s.flags;
        next_s.seq = SQ_EVHI;
      end
      SQ_EVHI: begin
        next_s.vrd = 1'b1;
        next_s.vaddr = s.vec;
        next_s.rd_tag = TG_VHI;
        next_s.seq = SQ_EVLO;
      end
      SQ_EVLO: begin
        next_s.vrd = 1'b1;
        next_s.vaddr = s.vec + VEC_STEP;
        next_s.rd_tag = TG_VLO;
        next_s.seq = SQ_EWAIT;
      end
      SQ_EWAIT: begin
        next_s.seq = SQ_EEND;
      end
      SQ_EEND: begin
        next_s.pcld = 1'b1;
        next_s.busy = 1'b0;
        if (s.seg_save) begin
          next_s.code_segment_reg = s.interrupt_segment_reg;
        end else begin
          next_s.use_isr = 1'b1;
        end
        next_s.seq = SQ_IDLE;
      end
      SQ_RCSR: begin
        next_s.pop = 1'b1;
        next_s.rd_tag = TG_CSR;
        next_s.seq = SQ_RPCH;
      end
      SQ_RPCH: begin
        next_s.pop = 1'b1;
        next_s.rd_tag = TG_PCH;
        next_s.seq = SQ_RPCL;
      end
      SQ_RPCL: begin
        next_s.pop = 1'b1;
        next_s.rd_tag = TG_PCL;
        next_s.seq = SQ_RWAIT;
      end
      SQ_RWAIT: begin
        next_s.seq = SQ_REND;
      end
      SQ_REND: begin
        next_s.pcld = 1'b1;
        next_s.flld = 1'b1;
        next_s.global_interrupt_enable = 1'b1;
        next_s.busy = 1'b0;
        next_s.tl_active = 1'b0;
        if (s.arbitration_mode_select && nest_top_valid) begin
          nest_pop = 1'b1;
          next_s.current_priority_level = nest_top;
        end
        if (!s.seg_save) begin
          // stay on interrupt segment only when returning into a nested routine
          next_s.use_isr = s.use_isr && s.arbitration_mode_select && nest_rest;
        end
        next_s.seq = SQ_IDLE;
      end
      default: next_s.seq = SQ_IDLE;
    endcase

    next_s.seg_out = next_s.use_isr ? next_s.interrupt_segment_reg : next_s.code_segment_reg;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
      s.seq <= SQ_IDLE;
      s.rd_tag <= TG_NONE;
      s.data_tag <= TG_NONE;
      s.current_priority_level <= CPL_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata = s.rdata;
  assign core_busy = s.busy;
  assign irq_ack = s.iack;
  assign ack_channel = s.chan;
  assign tl_ack = s.tlack;
  assign stk_push = s.push;
  assign stk_pop = s.pop;
  assign stk_wdata = s.wdata;
  assign vec_rd = s.vrd;
  assign vec_addr = s.vaddr;
  assign pc_load = s.pcld;
  assign pc_value = s.pc;
  assign flags_load = s.flld;
  assign flags_value = s.flags;
  assign code_seg = s.seg_out;
  assign int_seg = s.interrupt_segment_reg;
endmodule

// ### verif/ipa_core_properties.sv
/*
  Checker: port-level timing relations of ipa_core.
  Assumes binding to ipa_core and a single clock domain.
*/
module ipa_core_properties (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [ipa_pkg::NCH-1:0] irq_req,
  input wire logic tl_req,
  input wire logic instr_end,
  input wire logic iret_instr,
  input wire logic core_busy,
  input wire logic irq_ack,
  input wire logic [ipa_pkg::CH_W-1:0] ack_channel,
  input wire logic tl_ack,
  input wire logic stk_push,
  input wire logic stk_pop,
  input wire logic vec_rd,
  input wire logic [ipa_pkg::DATA_W-1:0] vec_addr,
  input wire logic pc_load,
  input wire logic flags_load
);
  timeunit 1ns;
  timeprecision 1ns;
  import ipa_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  logic [NCH-1:0] req_q;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      req_q <= '0;
    end else begin
      req_q <= irq_req;
    end
  end
  sequence s_pc_push;
    stk_push ##1 stk_push;
  endsequence
  sequence s_pops;
    stk_pop [*3];
  endsequence
  sequence s_vec_pair;
    vec_rd && vec_addr == $past(vec_addr) + 8'h01 ##2 pc_load;
  endsequence
  property p_ack_push;
    irq_ack |-> core_busy and s_pc_push;
  endproperty
  a_ack_push: assert property (p_ack_push) else $error("ack without pc pushes");
  property p_ack_cause;
    irq_ack |-> $past(instr_end) && !$past(core_busy) && req_q[ack_channel];
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_tl_grant;
    tl_ack |-> $past(tl_req) && !irq_ack && core_busy;
  endproperty
  a_tl_grant: assert property (p_tl_grant) else $error("bad top-level grant");
  property p_busy_hold;
    core_busy && $past(core_busy) |-> !irq_ack && !tl_ack;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("grant while busy");
  property p_vec_fetch;
    $rose(vec_rd) |=> s_vec_pair;
  endproperty
  a_vec_fetch: assert property (p_vec_fetch) else $error("vector fetch order");
  property p_ret_pops;
    iret_instr && !core_busy |=> !irq_ack and s_pops;
  endproperty
  a_ret_pops: assert property (p_ret_pops) else $error("return pops missing");
  property p_ret_end;
    flags_load |-> pc_load && !$past(stk_pop);
  endproperty
  a_ret_end: assert property (p_ret_end) else $error("return end misplaced");
  property p_pop_alone;
    stk_pop |-> !stk_push && !vec_rd && !pc_load;
  endproperty
  a_pop_alone: assert property (p_pop_alone) else $error("pop overlaps entry");
endmodule

bind ipa_core ipa_core_properties u_props (.sys_clk, .rst_b, .irq_req, .tl_req, .instr_end,
  .iret_instr, .core_busy, .irq_ack, .ack_channel, .tl_ack, .stk_push, .stk_pop, .vec_rd,
  .vec_addr, .pc_load, .flags_load);

// ### verif/ipa_core_model.sv
/*
  Partner: core-side system stack and vector memory.
  Assumes one-cycle answers after stk_pop and vec_rd.
*/
module ipa_core_model (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic stk_push,
  input wire logic stk_pop,
  input wire logic [ipa_pkg::DATA_W-1:0] stk_wdata,
  input wire logic vec_rd,
  input wire logic [ipa_pkg::DATA_W-1:0] vec_addr,
  output logic [ipa_pkg::DATA_W-1:0] stk_rdata,
  output logic [ipa_pkg::DATA_W-1:0] vec_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  import ipa_pkg::*;
  logic [DATA_W-1:0] mem[$];
  // last-in first-out; idle data lines toggle
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mem.delete();
      stk_rdata <= 8'h00;
      vec_rdata <= 8'h00;
    end else begin
      stk_rdata <= ~stk_rdata;
      vec_rdata <= ~vec_rdata;
      if (stk_push) mem.push_back(stk_wdata);
      if (stk_pop && mem.size() > 0) stk_rdata <= mem.pop_back();
      if (vec_rd) vec_rdata <= vec_addr ^ 8'hC3;
    end
  end
endmodule

// ### verif/tb_interrupt_priority_arbiter.sv
/*
  Testbench of ipa_core: register tasks, entry and return sequences.
  Assumes the core model answers stack and vector reads.
*/
module tb_interrupt_priority_arbiter;
  timeunit 1ns;
  timeprecision 1ns;
  import ipa_pkg::*;
  logic sys_clk, rst_b, reg_wr, reg_rd, tl_req, instr_end, ei_instr, iret_instr;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, flags_in, stk_rdata, vec_rdata, stk_wdata;
  logic [DATA_W-1:0] vec_addr, flags_value, code_seg, int_seg;
  logic [NCH-1:0] irq_req;
  logic [NCH*PRIO_W-1:0] irq_prio;
  logic [NCH*DATA_W-1:0] irq_vector;
  logic [PC_W-1:0] pc_in, pc_value;
  logic core_busy, irq_ack, tl_ack, stk_push, stk_pop, vec_rd, pc_load, flags_load;
  logic [CH_W-1:0] ack_channel;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;
  wire [1:0] ev = {pc_load, irq_ack | tl_ack};
  ipa_core dut (.*);
  ipa_core_model core (.*);
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  task tally_and_finish;
    if (n_errors == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task rdc(input logic [3:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task pulse(input logic [2:0] s);
    @(posedge sys_clk);
    {iret_instr, ei_instr, instr_end} <= s;
    @(posedge sys_clk);
    {iret_instr, ei_instr, instr_end} <= 3'b000;
    #1;
  endtask
  task waitev(input int b);
    int i;
    i = 0;
    while (ev[b] !== 1'b1 && i < 30) begin
      @(posedge sys_clk);
      #1;
      i++;
    end
    chk(ev[b], 1'b1);
  endtask
  function automatic logic [15:0] epc(input logic [7:0] v);
    return {v ^ 8'hC3, (v + 8'h01) ^ 8'hC3};
  endfunction
  // entry attempt; ok selects grant or refusal
  task ent(input logic [4:0] ch, input bit ok);
    pulse(3'b001);
    if (ok) begin
      waitev(0);
      chk(ack_channel, ch);
      waitev(1);
      chk(pc_value, epc(8'h20 + 8'(2 * ch)));
      @(posedge sys_clk);
      irq_req <= '0;
    end else begin
      repeat (8) begin
        @(posedge sys_clk);
        #1 chk(irq_ack, 1'b0);
      end
    end
  endtask
  task ret;
    pulse(3'b100);
    waitev(1);
    chk(pc_value, pc_in);
    chk(flags_value, flags_in);
  endtask
  initial begin
    {rst_b, reg_wr, reg_rd, tl_req, instr_end, ei_instr, iret_instr} = '0;
    reg_addr = '0;
    reg_wdata = '0;
    irq_req = '0;
    irq_prio = {NCH{3'h3}};
    for (int i = 0; i < NCH; i++) irq_vector[8*i +: 8] = 8'h20 + 8'(2 * i);
    pc_in = 16'h1234;
    flags_in = 8'h5A;
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    rdc(4'h0, 8'h07);
    rdc(4'hF, 8'h00);
    wr(4'h0, 8'h05);
    rdc(4'h0, 8'h05);
    wr(4'h0, 8'h07);
    for (int i = 0; i < NCH - 1; i++) begin
      @(posedge sys_clk);
      irq_req <= 24'h3 << i;
      pulse(3'b010);
      ent(5'(i), 1'b1);
    end
    rdc(4'h0, 8'h07);
    rdc(4'h6, 8'h16);
    @(posedge sys_clk);
    irq_req <= 24'h10;
    ent(5'h04, 1'b0);
    pulse(3'b010);
    ent(5'h04, 1'b1);
    ret();
    rdc(4'h0, 8'h17);
    wr(4'h0, 8'h13);
    @(posedge sys_clk);
    irq_req <= 24'h40;
    ent(5'h06, 1'b0);
    @(posedge sys_clk);
    irq_prio[18 +: 3] <= 3'h2;
    ent(5'h06, 1'b1);
    ret();
    @(posedge sys_clk);
    irq_prio[18 +: 3] <= 3'h3;
    wr(4'h2, 8'h3C);
    wr(4'h3, 8'hA5);
    #1 chk(int_seg, 8'hA5);
    for (int s = 0; s < 2; s++) begin
      wr(4'h4, 8'(s));
      wr(4'h0, 8'h17);
      @(posedge sys_clk);
      irq_req <= 24'h1;
      ent(5'h00, 1'b1);
      #1 chk(code_seg, 8'hA5);
      ret();
      chk(code_seg, 8'h3C);
    end
    wr(4'h4, 8'h00);
    wr(4'h0, 8'h07);
    wr(4'h4, 8'h02);
    rdc(4'h4, 8'h02);
    @(posedge sys_clk);
    tl_req <= 1'b1;
    pulse(3'b001);
    chk(tl_ack, 1'b0);
    wr(4'h4, 8'h00);
    @(posedge sys_clk);
    tl_req <= 1'b1;
    pulse(3'b001);
    waitev(0);
    chk(tl_ack, 1'b1);
    waitev(1);
    chk(pc_value, epc(TL_VECTOR));
    rdc(4'h5, 8'h06);
    @(posedge sys_clk);
    tl_req <= 1'b0;
    irq_req <= 24'h1;
    pulse(3'b010);
    ent(5'h00, 1'b0);
    ret();
    @(posedge sys_clk);
    irq_req <= '0;
    wr(4'h0, 8'h37);
    @(posedge sys_clk);
    irq_prio[2:0] <= 3'h4;
    irq_prio[5:3] <= 3'h4;
    irq_req <= 24'h1;
    ent(5'h00, 1'b1);
    rdc(4'h0, 8'h24);
    rdc(4'h1, 8'h80);
    pulse(3'b010);
    @(posedge sys_clk);
    irq_req <= 24'h2;
    ent(5'h01, 1'b0);
    @(posedge sys_clk);
    irq_prio[5:3] <= 3'h2;
    ent(5'h01, 1'b1);
    rdc(4'h0, 8'h22);
    rdc(4'h1, 8'h90);
    ret();
    rdc(4'h0, 8'h34);
    rdc(4'h1, 8'h80);
    ret();
    rdc(4'h0, 8'h37);
    rdc(4'h1, 8'h00);
    tally_and_finish();
  end
endmodule
